// [rtl/tdh_pkg.sv]
package tdh_pkg;
  // Clock and timing
  localparam int CLK_MHZ = 250;
  localparam int T_MIN_NS = 1000;
  // Least times round up to whole cycles
  localparam int CYC_1US_I = (T_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 9;
  localparam logic [CNT_W-1:0] CYC_1US = CYC_1US_I[CNT_W-1:0];
  localparam logic [CNT_W-1:0] CNT_ZERO = 9'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 9'h001;

  // Line widths
  localparam int CMD_W = 5;
  localparam int RD_W = 9;
  localparam int RD_PAR = 8;
  localparam int UNIT_W = 2;

  // Status inputs of the drive mechanism, bit positions
  localparam int STAT_W = 11;
  localparam int ST_LOAD_POINT = 0;
  localparam int ST_HARD_ERR = 1;
  localparam int ST_TAPE_MARK = 2;
  localparam int ST_ID_BURST = 3;
  localparam int ST_TAPE_END = 4;
  localparam int ST_DENSITY = 5;
  localparam int ST_WPROT = 6;
  localparam int ST_RSTROBE = 7;
  localparam int ST_WSTROBE = 8;
  localparam int ST_HSPEED = 9;
  localparam int ST_CERR = 10;

  // Host register map (byte addresses)
  localparam int RA_W = 5;
  localparam logic [RA_W-1:0] RA_CTRL = 5'h00;
  localparam logic [RA_W-1:0] RA_CMD = 5'h04;
  localparam logic [RA_W-1:0] RA_OP = 5'h08;
  localparam logic [RA_W-1:0] RA_STATUS = 5'h0c;
  localparam logic [RA_W-1:0] RA_IRQ_STAT = 5'h10;
  localparam logic [RA_W-1:0] RA_IRQ_CLR = 5'h14;
  localparam logic [RA_W-1:0] RA_IRQ_EN = 5'h18;
  localparam logic [RA_W-1:0] RA_RDATA = 5'h1c;

  // Field positions
  localparam int CTRL_ADDR_LSB = 0;
  localparam int CTRL_FEN = 2;
  localparam int OP_REWIND = 0;
  localparam int IRQ_W = 3;
  localparam int IRQ_CMD_DONE = 0;
  localparam int IRQ_REW_DONE = 1;
  localparam int IRQ_PULSE_SENT = 2;
  localparam int HST_W = 7;
  localparam int HST_SEQ_BUSY = 6;

  // Reset values
  localparam logic [UNIT_W-1:0] CTRL_ADDR_RST = 2'h0;
  localparam logic CTRL_FEN_RST = 1'h1;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

  typedef enum logic [1:0] {
    TDH_IDLE = 2'b00,
    TDH_SETTLE = 2'b01,
    TDH_PULSE = 2'b10
  } tdh_seq_t;

  typedef enum logic [1:0] {
    TDH_OP_NONE = 2'b00,
    TDH_OP_START = 2'b01,
    TDH_OP_REWIND = 2'b10
  } tdh_op_t;
endpackage

// [rtl/tdh_if.sv]
`timescale 1ns/10ps
// All lines are low when true
interface tdh_if;
  logic formatter_enable_in_n;
  logic go_offline_pulse_n;
  logic rewind_request_pulse_n;
  logic start_cmd_pulse_n;
  logic formatter_addr_line_n;
  logic target_addr_bit0_n;
  logic target_addr_bit1_n;
  logic [4:0] cmd_sel_n;
  logic [7:0] read_data_n;
  logic read_parity_out_n;
  logic load_point_out_n;
  logic hard_error_out_n;
  logic tape_mark_out_n;
  logic id_burst_out_n;
  logic tape_end_out_n;
  logic density_out_n;
  logic drive_ready_out_n;
  logic rewinding_out_n;
  logic write_protect_out_n;
  logic read_strobe_out_n;
  logic write_strobe_out_n;
  logic data_busy_out_n;
  logic high_speed_out_n;
  logic corrected_error_out_n;
  logic online_out_n;
  logic formatter_busy_out_n;

  modport dev (
    input formatter_enable_in_n, go_offline_pulse_n, rewind_request_pulse_n, start_cmd_pulse_n,
    input formatter_addr_line_n, target_addr_bit0_n, target_addr_bit1_n, cmd_sel_n,
    output read_data_n, read_parity_out_n, load_point_out_n, hard_error_out_n, tape_mark_out_n,
    output id_burst_out_n, tape_end_out_n, density_out_n, drive_ready_out_n, rewinding_out_n,
    output write_protect_out_n, read_strobe_out_n, write_strobe_out_n, data_busy_out_n,
    output high_speed_out_n, corrected_error_out_n, online_out_n, formatter_busy_out_n
  );

  modport host (
    output formatter_enable_in_n, go_offline_pulse_n, rewind_request_pulse_n, start_cmd_pulse_n,
    output formatter_addr_line_n, target_addr_bit0_n, target_addr_bit1_n, cmd_sel_n,
    input read_data_n, read_parity_out_n, load_point_out_n, hard_error_out_n, tape_mark_out_n,
    input id_burst_out_n, tape_end_out_n, density_out_n, drive_ready_out_n, rewinding_out_n,
    input write_protect_out_n, read_strobe_out_n, write_strobe_out_n, data_busy_out_n,
    input high_speed_out_n, corrected_error_out_n, online_out_n, formatter_busy_out_n
  );
endinterface

// [rtl/tdh_drive.sv]
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
module tdh_drive
  import tdh_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic srst_i,
  tdh_if.dev link,
  input wire logic [UNIT_W-1:0] unit_sel_i,
  input wire logic online_i,
  input wire logic data_busy_i,
  input wire logic cmd_done_i,
  input wire logic rewind_done_i,
  input wire logic [RD_W-1:0] rd_data_i,
  input wire logic [STAT_W-1:0] stat_i,
  output logic cmd_start_o,
  output logic [CMD_W-1:0] cmd_code_o,
  output logic rewind_start_o,
  output logic cmd_abort_o,
  output logic overrun_o
);
  localparam int HIN_W = CMD_W + 6;
  localparam logic [HIN_W-1:0] HIN_ZERO = 11'h000;

  logic [HIN_W-1:0] hin_meta;
  logic [HIN_W-1:0] hin;
  logic go_prev;
  logic rew_prev;
  logic fbusy;
  logic armed;
  logic rew_wait;
  logic rewinding;
  logic [CNT_W-1:0] rew_cnt;

  // Line levels turned to true-high before the synchroniser
  wire [HIN_W-1:0] hin_raw = ~{link.formatter_enable_in_n, link.rewind_request_pulse_n,
    link.start_cmd_pulse_n, link.formatter_addr_line_n, link.target_addr_bit1_n,
    link.target_addr_bit0_n, link.cmd_sel_n};

  // Two-flop synchroniser; only hin is looked at.
  // One pair of flops for all lines keeps command and start together,
  // at the cost of two clocks of latency.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      hin_meta <= HIN_ZERO;
      hin <= HIN_ZERO;
    end else begin
      hin_meta <= hin_raw;
      hin <= hin_meta;
    end
  end

  // Decoded synchronised lines
  wire [CMD_W-1:0] cmd_sel = hin[CMD_W-1:0];
  wire [UNIT_W-1:0] tad = hin[CMD_W+1:CMD_W];
  wire fad = hin[CMD_W+2];
  wire go = hin[CMD_W+3];
  wire rew = hin[CMD_W+4];
  wire fen = hin[CMD_W+5];
  wire addressed = ~fad && (tad == unit_sel_i);
  wire go_rise = go && !go_prev;
  wire go_fall = !go && go_prev;
  wire rew_rise = rew && !rew_prev;
  wire any_busy = fbusy || data_busy_i;
  wire go_take = go_rise && addressed && online_i && !any_busy;
  wire go_over = go_rise && addressed && online_i && any_busy;
  wire rew_take = rew_rise && addressed && online_i && !fbusy && !rew_wait && !rewinding;
  wire abort = online_i && !fen;
  wire ready = online_i && !rewinding;

  // Enable dropping stops the command; ignored while offline
  assign cmd_abort_o = abort;

  // Edge history of the synchronised strobes
  // Cleared to the false level, so no edge follows reset
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      go_prev <= 1'b0;
      rew_prev <= 1'b0;
    end else begin
      go_prev <= go;
      rew_prev <= rew;
    end
  end

  // Command acceptance, busy and capture at trailing edge
  // Limitation: a start shorter than one clock may be missed
  // Busy rises at the leading edge, long before the capture
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      fbusy <= 1'b0;
      armed <= 1'b0;
      cmd_start_o <= 1'b0;
      cmd_code_o <= '0;
    end else begin
      if (go_take) begin
        fbusy <= 1'b1;
      end else if (cmd_done_i || abort) begin
        fbusy <= 1'b0;
      end
      if (go_take) begin
        armed <= 1'b1;
      end else if (go_fall || abort) begin
        armed <= 1'b0;
      end
      cmd_start_o <= armed && go_fall && !abort;
      if (armed && go_fall) begin
        cmd_code_o <= cmd_sel;
      end
    end
  end

  // Overrun is cleared by the next accepted command
  // Set and clear never meet: a start is either taken or refused
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      overrun_o <= 1'b0;
    end else if (go_over) begin
      overrun_o <= 1'b1;
    end else if (go_take) begin
      overrun_o <= 1'b0;
    end
  end

  // Rewind: one microsecond after the leading edge, ready falls
  // Counting from the synchronised edge adds a few clocks of lag
  // A second rewind while counting or rewinding is ignored
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rew_wait <= 1'b0;
      rew_cnt <= CNT_ZERO;
      rewinding <= 1'b0;
      rewind_start_o <= 1'b0;
    end else begin
      rewind_start_o <= 1'b0;
      if (rew_take) begin
        rew_wait <= 1'b1;
        rew_cnt <= CYC_1US;
      end else if (rew_wait) begin
        rew_cnt <= rew_cnt - CNT_ONE;
        if (rew_cnt == CNT_ONE) begin
          rew_wait <= 1'b0;
          rewinding <= 1'b1;
          rewind_start_o <= 1'b1;
        end
      end else if (rewind_done_i || !online_i) begin
        rewinding <= 1'b0;
      end
    end
  end

  // Output lines, registered; a drive not addressed leaves them false
  // Registered so no decode glitch reaches the cable
  // Forcing false stands in for the chain's shared drivers
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || !addressed) begin
      link.read_data_n <= 8'hff;
      link.read_parity_out_n <= 1'b1;
      link.load_point_out_n <= 1'b1;
      link.hard_error_out_n <= 1'b1;
      link.tape_mark_out_n <= 1'b1;
      link.id_burst_out_n <= 1'b1;
      link.tape_end_out_n <= 1'b1;
      link.density_out_n <= 1'b1;
      link.drive_ready_out_n <= 1'b1;
      link.rewinding_out_n <= 1'b1;
      link.write_protect_out_n <= 1'b1;
      link.read_strobe_out_n <= 1'b1;
      link.write_strobe_out_n <= 1'b1;
      link.data_busy_out_n <= 1'b1;
      link.high_speed_out_n <= 1'b1;
      link.corrected_error_out_n <= 1'b1;
      link.online_out_n <= 1'b1;
      link.formatter_busy_out_n <= 1'b1;
    end else begin
      link.read_data_n <= ~rd_data_i[RD_PAR-1:0];
      link.read_parity_out_n <= ~rd_data_i[RD_PAR];
      link.load_point_out_n <= ~stat_i[ST_LOAD_POINT];
      link.hard_error_out_n <= ~stat_i[ST_HARD_ERR];
      link.tape_mark_out_n <= ~stat_i[ST_TAPE_MARK];
      link.id_burst_out_n <= ~stat_i[ST_ID_BURST];
      link.tape_end_out_n <= ~stat_i[ST_TAPE_END];
      link.density_out_n <= ~stat_i[ST_DENSITY];
      link.drive_ready_out_n <= ~ready;
      link.rewinding_out_n <= ~rewinding;
      link.write_protect_out_n <= ~stat_i[ST_WPROT];
      link.read_strobe_out_n <= ~stat_i[ST_RSTROBE];
      link.write_strobe_out_n <= ~stat_i[ST_WSTROBE];
      link.data_busy_out_n <= ~data_busy_i;
      link.high_speed_out_n <= ~stat_i[ST_HSPEED];
      link.corrected_error_out_n <= ~stat_i[ST_CERR];
      link.online_out_n <= ~online_i;
      link.formatter_busy_out_n <= ~fbusy;
    end
  end
endmodule

// [rtl/tdh_host.sv]
`timescale 1ns/10ps
module tdh_host
  import tdh_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic srst_i,
  tdh_if.host link,
  input wire logic [RA_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic irq_o
);
  localparam int DIN_W = RD_W + 6;
  localparam logic [DIN_W-1:0] DIN_ZERO = 15'h0000;

  logic [DIN_W-1:0] din_meta;
  logic [DIN_W-1:0] din;
  logic [DIN_W-1:0] din_prev;
  tdh_seq_t state;
  tdh_op_t pend;
  logic [CNT_W-1:0] cnt;
  logic [UNIT_W-1:0] sel_addr;
  logic fen;
  logic [CMD_W-1:0] cmd_code;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_en;

  // Device lines to true-high, then synchronised
  wire [DIN_W-1:0] din_raw = ~{link.hard_error_out_n, link.online_out_n, link.rewinding_out_n,
    link.drive_ready_out_n, link.data_busy_out_n, link.formatter_busy_out_n,
    link.read_parity_out_n, link.read_data_n};

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      din_meta <= DIN_ZERO;
      din <= DIN_ZERO;
      din_prev <= DIN_ZERO;
    end else begin
      din_meta <= din_raw;
      din <= din_meta;
      din_prev <= din;
    end
  end

  // Synchronised status and decode of the register port
  wire fmt_busy = din[RD_W];
  wire dbby = din[RD_W+1];
  wire rwd = din[RD_W+3];
  wire [HST_W-1:0] status = {state != TDH_IDLE, din[DIN_W-1:RD_W]};
  wire idle = (state == TDH_IDLE);
  wire wr_ctrl = reg_wr_i && (reg_addr_i == RA_CTRL);
  wire wr_cmd = reg_wr_i && (reg_addr_i == RA_CMD) && idle;
  wire wr_op = reg_wr_i && (reg_addr_i == RA_OP) && idle && reg_wdata_i[OP_REWIND];
  wire wr_clr = reg_wr_i && (reg_addr_i == RA_IRQ_CLR);
  wire wr_en = reg_wr_i && (reg_addr_i == RA_IRQ_EN);
  wire [UNIT_W-1:0] new_addr = reg_wdata_i[CTRL_ADDR_LSB+UNIT_W-1:CTRL_ADDR_LSB];
  // Address may only move while idle and neither busy line is up
  wire ctrl_ok = wr_ctrl && idle && !fmt_busy && !dbby;
  wire addr_move = ctrl_ok && (new_addr != sel_addr);
  wire pulse_end = (state == TDH_PULSE) && (cnt == CNT_ONE);
  wire [IRQ_W-1:0] ev = {pulse_end, !rwd && din_prev[RD_W+3], !fmt_busy && din_prev[RD_W]};

  // Strobe lines are combinational from the sequencer state
  wire go_line = (state == TDH_PULSE) && (pend == TDH_OP_START);
  wire rew_line = (state == TDH_PULSE) && (pend == TDH_OP_REWIND);
  wire fen_line = fen && !((state == TDH_SETTLE) && (pend == TDH_OP_NONE));
  assign link.start_cmd_pulse_n = ~go_line;
  assign link.rewind_request_pulse_n = ~rew_line;
  assign link.go_offline_pulse_n = 1'b1;
  assign link.formatter_enable_in_n = ~fen_line;
  assign link.formatter_addr_line_n = 1'b1;
  assign link.target_addr_bit0_n = ~sel_addr[0];
  assign link.target_addr_bit1_n = ~sel_addr[1];
  assign link.cmd_sel_n = ~cmd_code;

  // Read mux; unmapped and write-only offsets read zero
  wire [31:0] rd_mux =
    (reg_addr_i == RA_CTRL) ? {29'h0, fen, sel_addr} :
    (reg_addr_i == RA_STATUS) ? {25'h0, status} :
    (reg_addr_i == RA_IRQ_STAT) ? {29'h0, irq_stat} :
    (reg_addr_i == RA_IRQ_EN) ? {29'h0, irq_en} :
    (reg_addr_i == RA_RDATA) ? {23'h0, din[RD_W-1:0]} : 32'h0;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 32'h0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0;
    end
  end

  // Control registers; a refused write changes nothing
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      sel_addr <= CTRL_ADDR_RST;
      fen <= CTRL_FEN_RST;
      cmd_code <= '0;
      irq_en <= IRQ_RST;
    end else begin
      if (ctrl_ok) begin
        sel_addr <= new_addr;
        fen <= reg_wdata_i[CTRL_FEN];
      end
      if (wr_cmd) begin
        cmd_code <= reg_wdata_i[CMD_W-1:0];
      end
      if (wr_en) begin
        irq_en <= reg_wdata_i[IRQ_W-1:0];
      end
    end
  end

  // Sequencer: settle one microsecond, then a one microsecond strobe.
  // Settling before every strobe costs 1us but keeps lines stable at the edge.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state <= TDH_SETTLE;
      pend <= TDH_OP_NONE;
      cnt <= CYC_1US;
    end else begin
      case (state)
        TDH_IDLE: begin
          if (addr_move || wr_cmd || wr_op) begin
            state <= TDH_SETTLE;
            cnt <= CYC_1US;
            pend <= wr_cmd ? TDH_OP_START : (wr_op ? TDH_OP_REWIND : TDH_OP_NONE);
          end
        end
        TDH_SETTLE: begin
          cnt <= cnt - CNT_ONE;
          if (cnt == CNT_ONE) begin
            cnt <= CYC_1US;
            state <= (pend == TDH_OP_NONE) ? TDH_IDLE : TDH_PULSE;
          end
        end
        TDH_PULSE: begin
          cnt <= cnt - CNT_ONE;
          if (pulse_end) begin
            state <= TDH_IDLE;
            pend <= TDH_OP_NONE;
          end
        end
        default: begin
          state <= TDH_IDLE;
          pend <= TDH_OP_NONE;
        end
      endcase
    end
  end

  // Sticky events; a new event wins over a clear in the same cycle
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      irq_stat <= IRQ_RST;
    end else begin
      irq_stat <= (irq_stat & ~(wr_clr ? reg_wdata_i[IRQ_W-1:0] : IRQ_RST)) | ev;
    end
  end

  // Level interrupt, high exactly while an enabled event stands
  assign irq_o = |(irq_stat & irq_en);
endmodule

// [verif/tdh_checker.sv]
`timescale 1ns/10ps
module tdh_checker
  import tdh_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic formatter_enable_in_n,
  input wire logic go_offline_pulse_n,
  input wire logic rewind_request_pulse_n,
  input wire logic start_cmd_pulse_n,
  input wire logic formatter_addr_line_n,
  input wire logic target_addr_bit0_n,
  input wire logic target_addr_bit1_n,
  input wire logic [4:0] cmd_sel_n,
  input wire logic formatter_busy_out_n,
  input wire logic data_busy_out_n,
  input wire logic drive_ready_out_n,
  input wire logic rewinding_out_n,
  input wire logic online_out_n
);
  logic [1:0] addr_prev = 2'h0;
  logic [9:0] addr_cnt = 10'h000;
  logic [9:0] go_cnt = 10'h000;
  logic [9:0] rew_cnt = 10'h000;
  wire [1:0] addr_now = {target_addr_bit1_n, target_addr_bit0_n};
  wire [9:0] one_us = 10'(CYC_1US);

  // Hold time of the address and strobe widths; no reset, so the settle inside reset counts too
  always_ff @(posedge ref_clk_i) begin
    addr_prev <= addr_now;
    if (addr_now != addr_prev) begin
      addr_cnt <= 10'h001;
    end else if (addr_cnt != 10'h3ff) begin
      addr_cnt <= addr_cnt + 10'h001;
    end
    go_cnt <= start_cmd_pulse_n ? 10'h000 : go_cnt + 10'h001;
    rew_cnt <= rewind_request_pulse_n ? 10'h000 : rew_cnt + 10'h001;
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (srst_i);

  addr_setup_a: assert property (($fell(start_cmd_pulse_n) || $fell(rewind_request_pulse_n) ||
    $fell(formatter_enable_in_n)) |-> addr_cnt >= one_us) else $error("Strobe before address settled");
  addr_quiet_a: assert property ($changed(addr_now) |-> start_cmd_pulse_n && rewind_request_pulse_n &&
    formatter_enable_in_n && go_offline_pulse_n) else $error("Address moved under a strobe");
  addr_idle_a: assert property ($changed(addr_now) |-> $past(formatter_busy_out_n) &&
    $past(data_busy_out_n)) else $error("Address moved while busy");
  go_width_a: assert property ($rose(start_cmd_pulse_n) |-> go_cnt >= one_us)
    else $error("Start pulse too short");
  rew_width_a: assert property ($rose(rewind_request_pulse_n) |-> rew_cnt >= one_us)
    else $error("Rewind pulse too short");
  cmd_steady_a: assert property (!start_cmd_pulse_n |-> $stable(cmd_sel_n))
    else $error("Command lines moved during start");
  busy_rise_a: assert property ($fell(start_cmd_pulse_n) && !online_out_n && !formatter_enable_in_n &&
    formatter_busy_out_n && data_busy_out_n |-> ##[1:250] !formatter_busy_out_n) else $error("Busy late");
  offline_go_a: assert property ($fell(start_cmd_pulse_n) && online_out_n |->
    ##1 formatter_busy_out_n [*8]) else $error("Start taken while offline");
  rew_answer_a: assert property ($fell(rewind_request_pulse_n) && !online_out_n && formatter_busy_out_n &&
    rewinding_out_n |-> ##245 rewinding_out_n ##[1:12] (!rewinding_out_n && drive_ready_out_n))
    else $error("Rewind answer timing wrong");
  rew_refuse_a: assert property ($fell(rewind_request_pulse_n) && (!formatter_busy_out_n || online_out_n)
    |-> ##260 rewinding_out_n) else $error("Rewind taken while busy or offline");
  fixed_lines_a: assert property (formatter_addr_line_n && go_offline_pulse_n)
    else $error("Formatter address or offline line driven");
endmodule

// [verif/tape_drive_host_command_port_test.sv]
`timescale 1ns/10ps
`define CHK(a, b) begin \
  check_count++; \
  if ((a) !== (b)) begin \
    err_count++; \
    $display("Error at %0t: got %0h expected %0h", $time, a, b); \
  end \
end
module tape_drive_host_command_port_test
  import tdh_pkg::*;
;
  typedef struct {logic [1:0] kind; logic [31:0] val; logic [31:0] mask;} tdh_exp_t;
  logic ref_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [RA_W-1:0] reg_addr_i = '0;
  logic [31:0] reg_wdata_i = '0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic rd_d1 = 1'b0;
  logic [UNIT_W-1:0] unit_sel_i = '0;
  logic online_i = 1'b1;
  logic data_busy_i = 1'b0;
  logic cmd_done_i = 1'b0;
  logic rewind_done_i = 1'b0;
  logic [RD_W-1:0] rd_data_i = '0;
  logic [STAT_W-1:0] stat_i = '0;
  logic [31:0] reg_rdata_o;
  logic [CMD_W-1:0] cmd_code_o;
  logic irq_o, cmd_start_o, rewind_start_o, cmd_abort_o, overrun_o;
  int err_count = 0;
  int check_count = 0;
  int seed = 5256;
  tdh_exp_t exp_q[$];

  tdh_if tdh_if_inst();
  tdh_drive tdh_drive_inst(.ref_clk_i, .srst_i, .link(tdh_if_inst), .unit_sel_i, .online_i, .data_busy_i,
    .cmd_done_i, .rewind_done_i, .rd_data_i, .stat_i, .cmd_start_o, .cmd_code_o, .rewind_start_o,
    .cmd_abort_o, .overrun_o);
  tdh_host tdh_host_inst(.ref_clk_i, .srst_i, .link(tdh_if_inst), .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .irq_o);
  tdh_checker tdh_checker_inst(.ref_clk_i, .srst_i,
    .formatter_enable_in_n(tdh_if_inst.formatter_enable_in_n), .go_offline_pulse_n(tdh_if_inst.go_offline_pulse_n),
    .rewind_request_pulse_n(tdh_if_inst.rewind_request_pulse_n), .start_cmd_pulse_n(tdh_if_inst.start_cmd_pulse_n),
    .formatter_addr_line_n(tdh_if_inst.formatter_addr_line_n), .target_addr_bit0_n(tdh_if_inst.target_addr_bit0_n),
    .target_addr_bit1_n(tdh_if_inst.target_addr_bit1_n), .cmd_sel_n(tdh_if_inst.cmd_sel_n),
    .formatter_busy_out_n(tdh_if_inst.formatter_busy_out_n), .data_busy_out_n(tdh_if_inst.data_busy_out_n),
    .drive_ready_out_n(tdh_if_inst.drive_ready_out_n), .rewinding_out_n(tdh_if_inst.rewinding_out_n),
    .online_out_n(tdh_if_inst.online_out_n));

  initial begin
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  task automatic print_verdict();
    if (err_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  task automatic wr(input logic [RA_W-1:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  // Expectation noted before the strobe, so the watcher never sees a result ahead of it
  task automatic rd(input logic [RA_W-1:0] a, input logic [31:0] v, input logic [31:0] m);
    exp_q.push_back('{2'h0, v, m});
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
  endtask

  // Bounded wait for the end of a strobe sequence, then clear every event
  task automatic wait_irq();
    int n = 0;
    while (irq_o !== 1'b1 && n < 2000) begin
      @(posedge ref_clk_i);
      n++;
    end
    if (irq_o !== 1'b1) begin
      err_count++;
      print_verdict();
    end else begin
      wr(RA_IRQ_CLR, 32'h7);
    end
  endtask

  task automatic send(input logic [4:0] code, input logic acc);
    if (acc) exp_q.push_back('{2'h1, 32'(code), 32'h1f});
    wr(RA_CMD, 32'(code));
    wait_irq();
  endtask

  task automatic done();
    cmd_done_i <= 1'b1;
    @(posedge ref_clk_i);
    cmd_done_i <= 1'b0;
    cyc(10);
  endtask

  // A result with no note pending is a command or rewind the drive should have refused
  task automatic got(input logic [1:0] k, input logic [31:0] v);
    tdh_exp_t e;
    if (exp_q.size() == 0) begin
      `CHK(k, 2'h3)
    end else begin
      e = exp_q.pop_front();
      `CHK({k, v & e.mask}, {e.kind, e.val & e.mask})
    end
  endtask

  // Result watcher
  always @(posedge ref_clk_i) begin
    rd_d1 <= reg_rd_i;
    if (rd_d1) got(2'h0, reg_rdata_o);
    if (cmd_start_o === 1'b1) got(2'h1, 32'(cmd_code_o));
    if (rewind_start_o === 1'b1) got(2'h2, 32'h0);
  end

  initial begin
    cyc(12);
    srst_i <= 1'b0;
    rd(RA_STATUS, 32'h40, 32'h40);
    `CHK(cmd_abort_o, 1'b1)
    cyc(260);
    `CHK(cmd_abort_o, 1'b0)
    rd(RA_CTRL, 32'h4, 32'hffffffff);
    rd(RA_IRQ_STAT, 32'h0, 32'hffffffff);
    rd(5'h1f, 32'h0, 32'hffffffff);
    wr(RA_IRQ_EN, 32'h4);
    // Read lines and status lines are inverted copies of the mechanism side
    repeat (4) begin
      rd_data_i <= RD_W'($random(seed));
      stat_i <= STAT_W'($random(seed));
      cyc(8);
      `CHK({tdh_if_inst.read_parity_out_n, tdh_if_inst.read_data_n}, ~rd_data_i)
      `CHK({tdh_if_inst.corrected_error_out_n, tdh_if_inst.high_speed_out_n, tdh_if_inst.write_strobe_out_n,
        tdh_if_inst.read_strobe_out_n, tdh_if_inst.write_protect_out_n, tdh_if_inst.density_out_n,
        tdh_if_inst.tape_end_out_n, tdh_if_inst.id_burst_out_n, tdh_if_inst.tape_mark_out_n,
        tdh_if_inst.hard_error_out_n, tdh_if_inst.load_point_out_n}, ~stat_i)
      rd(RA_RDATA, 32'(rd_data_i), 32'h1ff);
    end
    // Every command code, busy seen in status
    for (int c = 0; c < 32; c++) begin
      send(c[4:0], 1'b1);
      rd(RA_STATUS, 32'h1, 32'h1);
      done();
    end
    // Start while formatter busy, then while data busy
    for (int i = 0; i < 2; i++) begin
      if (i == 0) send(5'h04, 1'b1);
      else data_busy_i <= 1'b1;
      cyc(10);
      send(5'h05, 1'b0);
      `CHK(overrun_o, 1'b1)
      if (i == 0) done();
      else data_busy_i <= 1'b0;
      cyc(10);
      send(5'h07, 1'b1);
      `CHK(overrun_o, 1'b0)
      done();
    end
    // Offline: start and rewind both refused without a flag
    online_i <= 1'b0;
    cyc(10);
    `CHK(tdh_if_inst.online_out_n, 1'b1)
    send(5'h01, 1'b0);
    `CHK(overrun_o, 1'b0)
    wr(RA_OP, 32'h1);
    wait_irq();
    online_i <= 1'b1;
    cyc(10);
    // Rewind while busy is refused
    send(5'h02, 1'b1);
    wr(RA_OP, 32'h1);
    wait_irq();
    cyc(300);
    done();
    // Accepted rewind with the interrupt masked, then unmasked and cleared
    wr(RA_IRQ_EN, 32'h0);
    exp_q.push_back('{2'h2, 32'h0, 32'h0});
    wr(RA_OP, 32'h1);
    cyc(600);
    `CHK(irq_o, 1'b0)
    `CHK({tdh_if_inst.drive_ready_out_n, tdh_if_inst.rewinding_out_n}, 2'h2)
    rd(RA_STATUS, 32'h8, 32'hc);
    rewind_done_i <= 1'b1;
    @(posedge ref_clk_i);
    rewind_done_i <= 1'b0;
    cyc(10);
    rd(RA_IRQ_STAT, 32'h7, 32'h7);
    wr(RA_IRQ_EN, 32'h4);
    cyc(3);
    `CHK(irq_o, 1'b1)
    wr(RA_IRQ_CLR, 32'h7);
    cyc(3);
    `CHK(irq_o, 1'b0)
    // Each address against a matching and a foreign unit switch
    for (int a = 0; a < 4; a++) begin
      for (int k = 0; k < 2; k++) begin
        unit_sel_i <= UNIT_W'(a + k);
        wr(RA_CTRL, 32'(4 + a));
        cyc(300);
        `CHK({tdh_if_inst.target_addr_bit1_n, tdh_if_inst.target_addr_bit0_n}, ~UNIT_W'(a))
        `CHK(tdh_if_inst.online_out_n, k[0])
        send(5'h09, k == 0);
        if (k == 0) done();
      end
    end
    cyc(10);
    `CHK(exp_q.size() == 0, 1'b1)
    print_verdict();
  end
endmodule
